// [sdsx_core.sv]
/*
  clock suspend / power-down entry and exit, and byte mask handling for
  write and read bursts. assumes a controller on the same clock that keeps
  its own timing; no software registers.
*/
//
// Operation
// - clock-enable high after suspend restarts internal clock next cycle
// - power-down exit turns all disabled buffers back on
// - a new command is accepted one cycle after exit
// - byte mask acts as per-byte write data mask during writes
// - byte mask high disables read output drivers, low enables
// - clock-enable low during burst freezes internal clock, state intact
// - clock-enable low with banks idle enters power-down, buffers off
`timescale 1ns/10ps
`include "sdsx_params.svh"
module sdsx_core
  import sdsx_pkg::*;
#(
  parameter int DATA_W = `SDSX_DATA_WIDTH,
  parameter int ADDR_W = `SDSX_ADDR_WIDTH,
  parameter int BURST_LEN = `SDSX_BURST_LEN
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEnable,
  input wire sdsx_pkg::sdsx_cmd_s cmd,
  input wire logic [DATA_W/8-1:0] byteMask,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic [DATA_W/8-1:0] dataOutEn,
  output logic buffersOn,
  output logic internalClkRun,
  output logic cmdReady
);
  import sdsx_pkg::*;

  localparam int CNT_W = $clog2(BURST_LEN + 1);
  localparam int NB = DATA_W / 8;

  // refuse sizes that the byte lanes and the burst counter cannot serve
  if (DATA_W % 8 != 0 || BURST_LEN < 1 || ADDR_W < 1) begin : g_bad_params
    $error("sdsx_core: unsupported parameters");
  end

  typedef struct packed {
    sdsx_state_e state;
    sdsx_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] left;
    logic readPend;
    logic [NB-1:0] outEn;
    logic buffersOn;
    logic clkRun;
    logic cmdReady;
  } sdsx_core_t;

  sdsx_core_t st_reg, st_next;
  logic memWe;
  logic [NB-1:0] memBe;
  logic [DATA_W-1:0] memRd;

  // word store; current beat address, so read word and enable leave on one edge
  sdsx_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mem (
    .clock(clock),
    .writeEn(memWe),
    .byteEn(memBe),
    .addr(st_reg.addr),
    .writeData(dataIn),
    .readData(memRd)
  );

  // next-state: suspend, power-down and burst progress
  always_comb begin
    st_next = st_reg;
    memWe = 1'b0;
    memBe = '0;
    st_next.readPend = 1'b0;
    case (st_reg.state)
      SDSX_IDLE: begin
        st_next.cmdReady = 1'b1;
        if (!clkEnable) begin
          st_next.state = SDSX_PDOWN;
          st_next.buffersOn = 1'b0;
          st_next.clkRun = 1'b0;
          st_next.cmdReady = 1'b0;
        end else if (cmd.cmdWrite || cmd.cmdRead) begin
          st_next.state = SDSX_BURST;
          st_next.op = cmd.cmdWrite ? SDSX_OP_WRITE : SDSX_OP_READ;
          st_next.addr = cmd.addr;
          st_next.left = CNT_W'(BURST_LEN);
          st_next.cmdReady = 1'b0;
        end
      end
      SDSX_BURST: begin
        if (!clkEnable) begin
          st_next.state = SDSX_SUSPEND;
          st_next.clkRun = 1'b0;
        end else begin
          if (st_reg.op == SDSX_OP_WRITE) begin
            memWe = 1'b1;
            memBe = ~byteMask;
          end else begin
            st_next.readPend = 1'b1;
          end
          if (st_reg.left == CNT_W'(1)) begin
            st_next.state = SDSX_IDLE;
            st_next.op = SDSX_OP_NONE;
            st_next.left = '0;
            st_next.cmdReady = 1'b1;
          end else begin
            st_next.addr = st_reg.addr + ADDR_W'(1);
            st_next.left = st_reg.left - CNT_W'(1);
          end
        end
      end
      SDSX_SUSPEND: begin
        if (clkEnable) begin
          st_next.state = SDSX_BURST;
          st_next.clkRun = 1'b1;
        end
      end
      SDSX_PDOWN: begin
        if (clkEnable) begin
          st_next.state = SDSX_IDLE;
          st_next.buffersOn = 1'b1;
          st_next.clkRun = 1'b1;
          st_next.cmdReady = 1'b1;
        end
      end
      default: begin
        st_next.state = SDSX_IDLE;
      end
    endcase
    // mask high drives outputs off; enable lines up with the read word
    st_next.outEn = (st_reg.state == SDSX_BURST && st_reg.op == SDSX_OP_READ && clkEnable
                     && st_reg.buffersOn) ? ~byteMask : '0;
  end

  // registered state; the pin-level signals all come straight from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '{state: SDSX_IDLE, op: SDSX_OP_NONE, addr: '0, left: '0,
                  readPend: 1'b0, outEn: '0, buffersOn: 1'b1,
                  clkRun: 1'b1, cmdReady: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dataOut = memRd;
  assign dataOutEn = st_reg.outEn;
  assign buffersOn = st_reg.buffersOn;
  assign internalClkRun = st_reg.clkRun;
  assign cmdReady = st_reg.cmdReady;

  chk_suspend_exit: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_SUSPEND && clkEnable |=> internalClkRun)
    else $error("clock not resumed after suspend exit");
  chk_pdown_buffers: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_PDOWN && clkEnable |=> buffersOn)
    else $error("buffers stayed off after power-down exit");
  chk_exit_ready: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_PDOWN && clkEnable |=> cmdReady)
    else $error("not ready one cycle after exit");
  chk_write_mask: assert property (@(posedge clock) disable iff (rst)
    memWe |-> memBe == ~byteMask)
    else $error("write enables do not follow mask");
  chk_read_outen: assert property (@(posedge clock) disable iff (rst)
    dataOutEn == (st_reg.readPend ? ~$past(byteMask) : '0))
    else $error("read output enable wrong");
  chk_suspend_hold: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_SUSPEND && !clkEnable |=> $stable(st_reg.addr))
    else $error("state moved during suspend");
  chk_pdown_entry: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_IDLE && !clkEnable |=> !buffersOn ##0 !internalClkRun)
    else $error("power-down not entered");
  chk_addr_advance: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == SDSX_BURST && clkEnable && st_reg.left > CNT_W'(1)
    |=> st_reg.addr == $past(st_reg.addr) + ADDR_W'(1))
    else $error("burst address did not advance");

  cov_suspend: cover property (@(posedge clock) st_reg.state == SDSX_SUSPEND);
  cov_pdown_exit: cover property (@(posedge clock)
    st_reg.state == SDSX_PDOWN ##1 st_reg.state == SDSX_IDLE);
  cov_masked_write: cover property (@(posedge clock) memWe && byteMask != '0);
  cov_masked_read: cover property (@(posedge clock) st_reg.readPend && byteMask != '0);
endmodule // sdsx_core

// [sdsx_params.svh]
/*
  timing counts and widths for the suspend exit and data mask block.
  assumes a 10 mhz clock, included by the package and the top module.
*/
`ifndef SDSX_PARAMS_SVH
`define SDSX_PARAMS_SVH
`define SDSX_CLK_PERIOD_NS 100
`define SDSX_EXIT_TIME_NS 100
`define SDSX_EXIT_CYCLES ((`SDSX_EXIT_TIME_NS + `SDSX_CLK_PERIOD_NS - 1) / `SDSX_CLK_PERIOD_NS)
`define SDSX_DATA_WIDTH 32
`define SDSX_ADDR_WIDTH 4
`define SDSX_BURST_LEN 4
`define SDSX_RESET_MASK 4'hf
`endif

// [sdsx_pkg.sv]
/*
  types for the suspend exit and data mask block.
  assumes the params header sits in the same folder.
*/
`include "sdsx_params.svh"
package sdsx_pkg;
  typedef enum logic [3:0] {
    SDSX_IDLE = 4'b0001,
    SDSX_BURST = 4'b0010,
    SDSX_SUSPEND = 4'b0100,
    SDSX_PDOWN = 4'b1000
  } sdsx_state_e;
  typedef enum logic [1:0] {
    SDSX_OP_NONE = 2'h0,
    SDSX_OP_WRITE = 2'h1,
    SDSX_OP_READ = 2'h2
  } sdsx_op_e;
  // command from the controller, decoded
  typedef struct packed {
    logic cmdNop;
    logic cmdWrite;
    logic cmdRead;
    logic [`SDSX_ADDR_WIDTH-1:0] addr;
  } sdsx_cmd_s;
endpackage

// [sdsx_mem.sv]
/*
  small word memory with per-byte write enables and registered read data.
  assumes one clock and same-cycle address for read and write.
*/
`timescale 1ns/10ps
module sdsx_mem #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  input wire logic clock,
  input wire logic writeEn,
  input wire logic [DATA_W/8-1:0] byteEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0] readData
);
  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
  // masked lanes keep their old contents
  always_ff @(posedge clock) begin
    for (int i = 0; i < DATA_W/8; i++) begin
      if (writeEn && byteEn[i]) begin
        store[addr][i*8 +: 8] <= writeData[i*8 +: 8];
      end
    end
    readData <= store[addr];
  end
endmodule // sdsx_mem

// [sdsx_ctrl_model.sv]
/*
  controller model that drives commands, clock-enable, mask and data.
  assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/10ps
module sdsx_ctrl_model
  import sdsx_pkg::*;
(
  input wire logic clock,
  input wire logic cmdReady,
  output sdsx_pkg::sdsx_cmd_s cmd,
  output logic clkEnable,
  output logic [3:0] byteMask,
  output logic [31:0] dataIn
);
  // idle levels: nop, drivers masked off
  initial begin
    cmd = '{cmdNop: 1'b1, cmdWrite: 1'b0, cmdRead: 1'b0, addr: 4'h0};
    clkEnable = 1'b1;
    byteMask = 4'hf;
    dataIn = 32'h0;
  end
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // nop only, two cycles covers exit time
  task automatic clk_hold(input logic level);
    clkEnable = level;
    step();
    step();
  endtask
  task automatic burst(input logic wr, input logic [3:0] a, input logic [31:0] d [4],
      input logic [3:0] m [4], input int hold);
    int n;
    n = 0;
    // issue once ready or after 50 waits, mask used per lane
    while (cmdReady !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    cmd = '{cmdNop: 1'b0, cmdWrite: wr, cmdRead: !wr, addr: a};
    step();
    cmd = '{cmdNop: 1'b1, cmdWrite: 1'b0, cmdRead: 1'b0, addr: 4'h0};
    // read mask set after the command edge, so never twice in one time step
    if (!wr) byteMask = m[0];
    for (int i = 0; i < 4; i++) begin
      if (wr) begin
        dataIn = d[i];
        byteMask = m[i];
      end
      // suspend before the third beat, nop meanwhile
      if (i == 2 && hold > 0) begin
        clkEnable = 1'b0;
        repeat (hold) step();
        clkEnable = 1'b1;
        // exit edge carries no beat; the held word goes on the next one
        step();
      end
      step();
    end
    if (!wr) repeat (2) step();
    // released data line shows a changed value, not the last one
    dataIn = ~dataIn;
    byteMask = 4'hf;
  endtask
endmodule // sdsx_ctrl_model

// [tb_sdsx_core.sv]
/*
  self-checking bench for the suspend exit and data mask core.
  assumes the controller model and design files are compiled first.
*/
`timescale 1ns/10ps
module tb_sdsx_core;
  import sdsx_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  sdsx_cmd_s cmd;
  logic clkEnable, buffersOn, internalClkRun, cmdReady;
  logic [3:0] byteMask, dataOutEn;
  logic [31:0] dataIn, dataOut, r;
  logic [31:0] mem [16];
  logic [35:0] notes [$];
  logic [31:0] seed = 32'h7ef9a360;
  logic [31:0] d [4];
  logic [3:0] m [4];
  logic live = 1'b0;
  logic stopSeen = 1'b0;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  sdsx_core i_sdsx_core (.clock(clock), .rst(rst), .clkEnable(clkEnable), .cmd(cmd),
    .byteMask(byteMask), .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .buffersOn(buffersOn), .internalClkRun(internalClkRun), .cmdReady(cmdReady));
  sdsx_ctrl_model ctrl (.clock(clock), .cmdReady(cmdReady), .cmd(cmd),
    .clkEnable(clkEnable), .byteMask(byteMask), .dataIn(dataIn));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // xorshift beats; masked only when asked
  task automatic beats(input logic masked);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        if (k == 0) d[i] = seed;
        else m[i] = masked ? seed[3:0] : 4'h0;
      end
    end
  endtask
  // masked bytes keep old value, address still steps
  task automatic wr(input logic [3:0] a, input int hold);
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < 4; b++)
        if (!m[i][b]) mem[4'(a + i)][b*8+:8] = d[i][b*8+:8];
    ctrl.burst(1'b1, a, d, m, hold);
  endtask
  // a fully masked read shows no beat at all
  task automatic rd(input logic [3:0] a, input logic [3:0] mask);
    for (int i = 0; i < 4; i++)
      if (mask !== 4'hf) notes.push_back({~mask, mem[4'(a + i)]});
    m[0] = mask;
    ctrl.burst(1'b0, a, d, m, 0);
  endtask
  // hang guard: whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      finish_test();
    end
  end
  // watcher: each driven read beat takes the oldest note
  always @(posedge clock) begin
    logic [35:0] n;
    logic [31:0] bm;
    #2;
    if (!internalClkRun) stopSeen = 1'b1;
    if (live && dataOutEn !== 4'h0) begin
      n = notes.size() > 0 ? notes.pop_front() : 36'h0;
      for (int b = 0; b < 4; b++) bm[b*8+:8] = {8{n[32+b]}};
      check("read enable", n[35:32], dataOutEn);
      check("read data", n[31:0] & bm, dataOut & bm);
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    live = 1'b1;
    check("ready after reset", 1, cmdReady);
    check("drivers after reset", 0, dataOutEn);
    for (int a = 0; a < 16; a += 4) begin
      beats(1'b0);
      wr(4'(a), 0);
    end
    $display("test fill done");
    for (int j = 0; j < 6; j++) begin
      beats(1'b1);
      wr(d[0][7:4], 0);
    end
    $display("test masked writes done");
    beats(1'b1);
    wr(4'h6, 3);
    check("clock stopped in suspend", 1, stopSeen);
    check("clock resumed", 1, internalClkRun);
    $display("test suspend done");
    ctrl.clk_hold(1'b0);
    check("buffers off", 0, buffersOn);
    check("clock off in power-down", 0, internalClkRun);
    ctrl.clk_hold(1'b1);
    check("buffers back on", 1, buffersOn);
    check("clock on after exit", 1, internalClkRun);
    check("ready after exit", 1, cmdReady);
    $display("test power down done");
    for (int j = 0; j < 16; j++) begin
      beats(1'b1);
      rd(d[0][11:8], j == 3 ? 4'hf : m[0]);
    end
    repeat (6) @(posedge clock);
    check("notes left", 0, notes.size());
    $display("test reads done");
    finish_test();
  end
endmodule // tb_sdsx_core
